// *** hdl/time_scale_display_control.sv ***
// What this block does
// [RL1] Display latched count, or time in clock
// [RL2] Show one multiplexed BCD digit at once
// [RL3] Decode each digit to seven segments
// [RL4] Emit 15 ms pulses at 1 or 10 Hz
// [RL5] Retime pulses to 10 MHz reference ticks
// [RL6] Internal interval shows auxiliary scale delay
// [RL7] Diagnose ten faults, assume one at most
// [RL8] Fault: red on, green off, show number
// [RL9] Locked and healthy: green on, red off
// [RL10] Tune lamps beyond half volt threshold
// [RL11] Blanked display: scale lamps flash 1/10 Hz
// [RL12] Offset shown in ten's complement form
// [RL13] Gate times of 1, 10, 100 s
// [RL14] Start steps blinking digit, correction alters
// [RL15] Operator enters positive shift as complement
// [RL16] Start+Sync held, released: shift applied, zero
// [RL17] External sync zeroes divider on pulse
// [RL18] External interval shows difference, 0.1 us
// [RL19] Set mode edits time, count resumes
// [RL20] Time rolls 23:59:59 to 00:00:00
// [RL21] Latched value counts ticks since scale
// [RL22] Scan seven digits in equal slots
// [RL23] Debounce buttons, one action per press
module time_scale_display_control #(
	parameter int PULSE_TICKS = tsd_pkg::PULSE_TK,
	parameter int HOLD_TICKS  = tsd_pkg::HOLD_TK,
	parameter int DEB_TICKS   = tsd_pkg::DEB_TK,
	parameter int SCAN_TICKS  = tsd_pkg::SCAN_TK,
	parameter int GATE_TICKS  = tsd_pkg::GATE_TK
) (
	input  wire logic                        i_clk,
	input  wire logic                        i_rstn,
	input  wire tsd_pkg::buttons_s           i_buttons,
	input  wire logic                        i_ext_pulse,
	input  wire logic                        i_tune_pos,
	input  wire logic                        i_tune_neg,
	input  wire logic [9:0]                  i_fault,
	input  wire logic [tsd_pkg::ADDR_W-1:0]  i_addr,
	input  wire logic [31:0]                 i_wdata,
	input  wire logic                        i_wr,
	input  wire logic                        i_rd,
	output logic [31:0]                      o_rdata,
	output logic [6:0]                       o_segments,
	output logic [6:0]                       o_digit_sel,
	output logic [6:0]                       o_fault_segments,
	output tsd_pkg::indicator_lamp_s         o_lamps,
	output logic                             o_aux_pulse
);
	// Counts below one would stall the dividers
	if (PULSE_TICKS < 1 || HOLD_TICKS < 1 || DEB_TICKS < 1 || SCAN_TICKS < 1
		|| GATE_TICKS < 1) begin : bad_counts
		$error("time_scale_display_control: counts must be positive");
	end

	function automatic logic [27:0] bcd_inc(input logic [27:0] v);
		logic [27:0] r;
		logic        c;
		r = v;
		c = 1'b1;
		for (int i = 0; i < 7; i++) begin
			if (c) begin
				if (r[4*i+:4] == 4'h9) begin
					r[4*i+:4] = 4'h0;
				end else begin
					r[4*i+:4] = r[4*i+:4] + 4'h1;
					c = 1'b0;
				end
			end
		end
		return r;
	endfunction

	// Step one BCD digit or pair up or down, wrapping at mx
	function automatic logic [7:0] bcd_step(input logic [7:0] p, input logic [7:0] mx,
		input logic up);
		logic [7:0] r;
		r = p;
		if (up) begin
			if (p == mx) r = 8'h00;
			else if (p[3:0] == 4'h9) r = {p[7:4] + 4'h1, 4'h0};
			else r = p + 8'h01;
		end else begin
			if (p == 8'h00) r = mx;
			else if (p[3:0] == 4'h0) r = {p[7:4] - 4'h1, 4'h9};
			else r = p - 8'h01;
		end
		return r;
	endfunction

	// Segments g..a, blank for codes above nine
	function automatic logic [6:0] seg7(input logic [3:0] d);
		case (d)
			4'h0: seg7 = 7'h3f;
			4'h1: seg7 = 7'h06;
			4'h2: seg7 = 7'h5b;
			4'h3: seg7 = 7'h4f;
			4'h4: seg7 = 7'h66;
			4'h5: seg7 = 7'h6d;
			4'h6: seg7 = 7'h7d;
			4'h7: seg7 = 7'h07;
			4'h8: seg7 = 7'h7f;
			4'h9: seg7 = 7'h6f;
			default: seg7 = 7'h00;
		endcase
	endfunction

	tsd_pkg::st_s     s;
	tsd_pkg::st_s     next_s;
	tsd_pkg::buttons_s btn;
	tsd_pkg::buttons_s press;
	logic             tick;
	logic             mpulse;
	logic             ext_edge;
	logic             aux1;
	logic             aux_hit;
	logic             query;
	logic             gate_end;
	logic             set_mode;
	logic             blink;
	logic [6:0]       gate_lim;
	logic [27:0]      shown;
	logic [3:0]       digit;

	always_comb begin
		next_s = s;
		// Two-stage synchronisers for all panel inputs
		next_s.s1 = {i_buttons, i_ext_pulse, i_tune_pos, i_tune_neg, i_fault};
		next_s.s2 = s.s1;
		next_s.ext_prev = s.s2[12];
		ext_edge = s.s2[12] && !s.ext_prev;
		set_mode = s.ctrl.set_time && (s.fn == tsd_pkg::FN_TIME);

		// 10 MHz reference tick from the 40 MHz clock
		tick = (s.ph == 2'(tsd_pkg::REF_DIV - 1));
		next_s.ph = tick ? 2'h0 : s.ph + 2'h1;

		// Button debounce: two equal samples one slot apart
		press = '0;
		if (tick) begin
			if (s.deb_cnt >= 32'(DEB_TICKS - 1)) begin
				next_s.deb_cnt = '0;
				next_s.samp = s.s2[17:13];
				for (int i = 0; i < 5; i++) begin
					if (s.samp[i] == s.s2[13+i]) next_s.stable[i] = s.s2[13+i]; // RL23
				end
			end else begin
				next_s.deb_cnt = s.deb_cnt + 32'h1;
			end
		end
		btn = next_s.stable;
		press = next_s.stable & ~s.stable; // RL23

		// Main divider, and auxiliary scale from the shift
		// Main scale pulse is the divider wrapping back to zero
		mpulse = tick && (s.main == 28'h9999999) && (s.fn != tsd_pkg::FN_DF);
		aux1 = (s.main == s.shift);
		aux_hit = tick && (s.ctrl.rate_10hz ? (s.main[23:0] == s.shift[23:0]) : aux1);
		if (s.fn == tsd_pkg::FN_DF) begin
			if (ext_edge) next_s.main = bcd_inc(s.main);
		end else if (tick) begin
			next_s.main = bcd_inc(s.main);
		end

		// Interval query source and latch
		query = 1'b0;
		if (s.fn == tsd_pkg::FN_DT) begin
			query = s.ctrl.outside_reference_select ? ext_edge : (tick && aux1); // RL6 RL18
		end
		if (query) next_s.latched = s.main; // RL21

		// Offset gate: count beats, latch and restart at gate end
		case (s.ctrl.gate)
			2'h0: gate_lim = 7'd1;
			2'h1: gate_lim = 7'd10;
			default: gate_lim = 7'd100;
		endcase
		gate_end = 1'b0;
		if (s.fn == tsd_pkg::FN_DF && tick) begin
			if (s.gt_cnt >= 32'(GATE_TICKS - 1)) begin
				next_s.gt_cnt = '0;
				if (s.gate_n + 7'd1 >= gate_lim) begin // RL13
					next_s.gate_n = '0;
					gate_end = 1'b1;
				end else begin
					next_s.gate_n = s.gate_n + 7'd1;
				end
			end else begin
				next_s.gt_cnt = s.gt_cnt + 32'h1;
			end
		end else if (s.fn != tsd_pkg::FN_DF) begin
			next_s.gt_cnt = '0;
			next_s.gate_n = '0;
		end
		if (gate_end) begin
			next_s.latched = s.main; // RL12
			next_s.main = '0;
		end

		// Start+Sync held together, then released
		if (btn.start && btn.sync) begin
			if (tick && !s.combo_done) begin
				next_s.combo_cnt = s.combo_cnt + 32'h1;
				if (s.combo_cnt >= 32'(HOLD_TICKS - 1)) next_s.combo_done = 1'b1;
			end
		end else if (!btn.start && !btn.sync) begin
			next_s.combo_cnt = '0;
			next_s.combo_done = 1'b0;
			if (s.combo_done) next_s.armed = 1'b1; // RL16
		end
		if (s.armed && s.fn == tsd_pkg::FN_DT) begin
			if (s.ctrl.outside_reference_select && ext_edge) begin
				next_s.main = '0; // RL17
				next_s.armed = 1'b0;
			end else if (!s.ctrl.outside_reference_select && tick && aux1) begin
				next_s.main = '0; // RL16
				next_s.shift = '0;
				next_s.armed = 1'b0;
			end
		end else if (s.fn != tsd_pkg::FN_DT) begin
			next_s.armed = 1'b0;
		end

		// Function key cycles the display function
		if (press.next) next_s.fn = tsd_pkg::fn_e'(s.fn + 2'h1);

		// Start steps digit, correction edits it
		if (s.fn == tsd_pkg::FN_DT && !s.ctrl.outside_reference_select) begin
			if (press.start && !btn.sync) next_s.pos = (s.pos == 3'd6) ? 3'd0 : s.pos + 3'd1; // RL14
			if (press.plus || press.minus) begin
				next_s.shift[4*s.pos+:4] =
					4'(bcd_step({4'h0, s.shift[4*s.pos+:4]}, 8'h09, press.plus)); // RL14 RL15
			end
		end
		if (set_mode) begin
			if (press.start && !btn.sync) next_s.tpos = (s.tpos == 2'd2) ? 2'd0 : s.tpos + 2'd1; // RL19
			if (press.plus || press.minus) begin
				next_s.tod[8*s.tpos+:8] = bcd_step(s.tod[8*s.tpos+:8],
					(s.tpos == 2'd2) ? 8'h23 : 8'h59, press.plus); // RL19
			end
		end else if (mpulse) begin
			// Time of day counts on each main scale pulse
			next_s.tod[7:0] = bcd_step(s.tod[7:0], 8'h59, 1'b1); // RL20
			if (s.tod[7:0] == 8'h59) begin
				next_s.tod[15:8] = bcd_step(s.tod[15:8], 8'h59, 1'b1); // RL20
				if (s.tod[15:8] == 8'h59) next_s.tod[23:16] = bcd_step(s.tod[23:16], 8'h23, 1'b1);
			end
		end

		// Auxiliary output pulse, started and ended on ticks
		if (aux_hit && s.fn != tsd_pkg::FN_DF) begin
			next_s.ap_cnt = 32'(PULSE_TICKS); // RL4 RL5
		end else if (tick && s.ap_cnt != 32'h0) begin
			next_s.ap_cnt = s.ap_cnt - 32'h1;
		end
		next_s.aout = (next_s.ap_cnt != 32'h0);

		// Digit scan in equal slots
		if (tick) begin
			if (s.scan_cnt >= 32'(SCAN_TICKS - 1)) begin
				next_s.scan_cnt = '0;
				next_s.scan = (s.scan == 3'd6) ? 3'd0 : s.scan + 3'd1; // RL22
			end else begin
				next_s.scan_cnt = s.scan_cnt + 32'h1;
			end
		end

		// Digit selection and segment decode
		blink = s.main[24];
		shown = (s.fn == tsd_pkg::FN_TIME) ? {tsd_pkg::BLANK_D, s.tod} : s.latched; // RL1
		digit = shown[4*s.scan+:4]; // RL2
		if (blink && ((s.fn == tsd_pkg::FN_DT && !s.ctrl.outside_reference_select
			&& s.pos == s.scan) || (set_mode && s.scan[2:1] == s.tpos))) begin
			digit = tsd_pkg::BLANK_D; // RL14
		end
		next_s.seg = seg7(digit); // RL3
		next_s.dsel = (s.fn == tsd_pkg::FN_BLANK) ? 7'h00 : 7'(7'h01 << s.scan); // RL2

		// Fault number, lowest line wins
		next_s.fcode = 4'h0;
		for (int i = 9; i >= 0; i--) begin
			if (s.s2[i]) next_s.fcode = 4'(i + 1); // RL7
		end
		next_s.fseg = (s.fcode == 4'h0) ? 7'h00 : seg7((s.fcode == 4'ha) ? 4'h0 : s.fcode); // RL8
		next_s.lamp.red = (s.fcode != 4'h0); // RL8
		next_s.lamp.green = (s.fcode == 4'h0) && s.ctrl.frequency_lock_loop_switch; // RL9
		next_s.lamp.tune_plus = s.s2[11]; // RL10
		next_s.lamp.tune_minus = s.s2[10]; // RL10
		next_s.lamp.fn_t = (s.fn == tsd_pkg::FN_TIME);
		next_s.lamp.fn_dt = (s.fn == tsd_pkg::FN_DT);
		next_s.lamp.fn_df = (s.fn == tsd_pkg::FN_DF);
		next_s.lamp.scale_flash = (s.fn == tsd_pkg::FN_BLANK)
			&& (s.ctrl.rate_10hz ? (s.main[23:20] < 4'h5) : (s.main[27:24] < 4'h5)); // RL11

		// Register port
		if (i_wr && i_addr == tsd_pkg::A_CTRL) next_s.ctrl = i_wdata[5:0];
		next_s.rdata = '0;
		if (i_rd) begin
			case (i_addr)
				tsd_pkg::A_CTRL:   next_s.rdata = {26'h0, s.ctrl};
				tsd_pkg::A_STATUS: next_s.rdata = {17'h0, s.armed, s.fn, s.fcode, s.lamp};
				tsd_pkg::A_VALUE:  next_s.rdata = {4'h0, s.latched};
				tsd_pkg::A_TOD:    next_s.rdata = {8'h0, s.tod};
				tsd_pkg::A_SHIFT:  next_s.rdata = {4'h0, s.shift};
				default:           next_s.rdata = '0;
			endcase
		end
	end

	// State register
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign o_rdata = s.rdata;
	assign o_segments = s.seg;
	assign o_digit_sel = s.dsel;
	assign o_fault_segments = s.fseg;
	assign o_lamps = s.lamp;
	assign o_aux_pulse = s.aout;

	// Helper: length of the current output pulse in clocks
	logic [31:0] hi_run;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			hi_run <= '0;
		end else begin
			hi_run <= o_aux_pulse ? hi_run + 32'h1 : 32'h0;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	chk_pulse_len: assert property ($fell(o_aux_pulse) |-> // RL4
		hi_run == 32'(PULSE_TICKS * tsd_pkg::REF_DIV))
		else $error("aux pulse length wrong");
	chk_pulse_retime: assert property ($changed(o_aux_pulse) |-> $past(tick)) // RL5
		else $error("aux pulse edge not on reference tick");
	chk_one_digit: assert property ($onehot0(o_digit_sel)) // RL2
		else $error("more than one digit selected");
	chk_fault_lamps: assert property (s.fcode != 4'h0 |=> o_lamps.red && !o_lamps.green) // RL8
		else $error("fault lamps wrong");
	chk_green_ok: assert property (s.fcode == 4'h0 && s.ctrl.frequency_lock_loop_switch // RL9
		|=> o_lamps.green && !o_lamps.red)
		else $error("green lamp not lit");
	chk_tune_lamp: assert property (s.s2[11] |=> o_lamps.tune_plus) // RL10
		else $error("plus tuning lamp missing");
	chk_latch_count: assert property (query && !gate_end |=> s.latched == $past(s.main)) // RL21
		else $error("latched count wrong");
	chk_int_sync: assert property (s.armed && s.fn == tsd_pkg::FN_DT // RL16
		&& !s.ctrl.outside_reference_select && tick && aux1 |=> s.main == 28'h0 && s.shift == 28'h0
		&& !s.armed)
		else $error("sync did not zero divider");
	chk_tod_roll: assert property (mpulse && !set_mode && s.tod == 24'h235959 // RL20
		|=> s.tod == tsd_pkg::TOD_RST)
		else $error("time did not roll over");
	chk_blank_dark: assert property (s.fn == tsd_pkg::FN_BLANK |=> o_digit_sel == 7'h00) // RL11
		else $error("display not blanked");
	chk_ext_sync: assert property (s.armed && s.fn == tsd_pkg::FN_DT // RL17
		&& s.ctrl.outside_reference_select && ext_edge |=> s.main == 28'h0 && !s.armed)
		else $error("outside sync did not zero divider");
	chk_fault_digit: assert property (s.fcode == 4'h0 |=> o_fault_segments == 7'h00) // RL8
		else $error("fault digit lit without fault");

	cov_sync: cover property (s.armed ##1 !s.armed);
	cov_roll: cover property (mpulse && s.tod == 24'h235959);
	cov_fault: cover property ($rose(o_lamps.red));
	cov_press: cover property (press.start);
	cov_ext_sync: cover property (s.armed && s.ctrl.outside_reference_select && ext_edge);
endmodule

// *** hdl/tsd_pkg.sv ***
package tsd_pkg;
	// Clock and reference rates
	localparam int CLK_HZ   = 40_000_000;
	localparam int REF_HZ   = 10_000_000;
	localparam int REF_DIV  = CLK_HZ / REF_HZ;
	// Times in their own units, counts in 10 MHz ticks
	localparam int PULSE_MS = 15;
	localparam int PULSE_TK = REF_HZ / 1000 * PULSE_MS;
	localparam int HOLD_S   = 3;
	localparam int HOLD_TK  = REF_HZ * HOLD_S;
	localparam int DEB_MS   = 10;
	localparam int DEB_TK   = REF_HZ / 1000 * DEB_MS;
	localparam int SCAN_US  = 1000;
	localparam int SCAN_TK  = REF_HZ / 1_000_000 * SCAN_US;
	localparam int GATE_TK  = REF_HZ;
	// Register map, byte addresses
	localparam int          ADDR_W   = 5;
	localparam logic [4:0]  A_CTRL   = 5'h00;
	localparam logic [4:0]  A_STATUS = 5'h04;
	localparam logic [4:0]  A_VALUE  = 5'h08;
	localparam logic [4:0]  A_TOD    = 5'h0c;
	localparam logic [4:0]  A_SHIFT  = 5'h10;
	localparam logic [5:0]  CTRL_RST = 6'h00;
	localparam logic [23:0] TOD_RST  = 24'h000000;
	localparam logic [3:0]  BLANK_D  = 4'hf;

	typedef enum logic [1:0] {FN_TIME, FN_DT, FN_DF, FN_BLANK} fn_e;

	// Panel switches held in the control register
	typedef struct packed {
		logic       frequency_lock_loop_switch;
		logic       set_time;
		logic [1:0] gate;
		logic       rate_10hz;
		logic       outside_reference_select;
	} ctrl_s;

	typedef struct packed {
		logic next;
		logic minus;
		logic plus;
		logic sync;
		logic start;
	} buttons_s;

	typedef struct packed {
		logic green;
		logic red;
		logic tune_plus;
		logic tune_minus;
		logic fn_t;
		logic fn_dt;
		logic fn_df;
		logic scale_flash;
	} indicator_lamp_s;

	typedef struct packed {
		logic [17:0]     s1;
		logic [17:0]     s2;
		logic            ext_prev;
		logic [1:0]      ph;
		logic [27:0]     main;
		logic [27:0]     latched;
		logic [27:0]     shift;
		logic [23:0]     tod;
		fn_e             fn;
		logic [2:0]      pos;
		logic [1:0]      tpos;
		logic            armed;
		logic            combo_done;
		logic [6:0]      gate_n;
		logic [31:0]     gt_cnt;
		logic [31:0]     deb_cnt;
		logic [31:0]     combo_cnt;
		logic [31:0]     scan_cnt;
		logic [31:0]     ap_cnt;
		logic [4:0]      samp;
		logic [4:0]      stable;
		logic [2:0]      scan;
		logic [3:0]      fcode;
		ctrl_s           ctrl;
		logic [6:0]      seg;
		logic [6:0]      dsel;
		logic [6:0]      fseg;
		indicator_lamp_s lamp;
		logic            aout;
		logic [31:0]     rdata;
	} st_s;
endpackage

// *** sim/panel_operator_model.sv ***
// Front-panel operator: buttons, fault and tune levels, outside pulse
module panel_operator_model (
	input  wire logic                 i_clk,
	output tsd_pkg::buttons_s         o_buttons,
	output logic                      o_ext_pulse,
	output logic                      o_tune_pos,
	output logic                      o_tune_neg,
	output logic [9:0]                o_fault
);
	timeunit 1ns;
	timeprecision 1ps;

	int unsigned ext_cnt;

	initial begin
		o_buttons = '0;
		o_fault = 10'h000;
		o_tune_pos = 1'b0;
		o_tune_neg = 1'b0;
		o_ext_pulse = 1'b0;
		ext_cnt = 0;
	end

	// Outside scale pulse, short high every 400 clocks
	always @(posedge i_clk) begin
		ext_cnt <= (ext_cnt == 399) ? 0 : ext_cnt + 1;
		o_ext_pulse <= (ext_cnt < 4);
	end

	// Press held steady well past the debounce, then released
	task automatic press(input logic [4:0] b, input int n);
		@(posedge i_clk);
		o_buttons <= tsd_pkg::buttons_s'(b);
		repeat (n) @(posedge i_clk);
		o_buttons <= '0;
		repeat (48) @(posedge i_clk);
	endtask

	// Only one fault line at a time, tune lamps never both
	task automatic set_inputs(input logic [9:0] f, input logic p, input logic n);
		@(posedge i_clk);
		o_fault <= f;
		o_tune_pos <= p;
		o_tune_neg <= n;
		repeat (10) @(posedge i_clk);
	endtask
endmodule

// *** sim/time_scale_display_control_tb_top.sv ***
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected at %0t: got %0h want %0h", $time, g, e); end end

module time_scale_display_control_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [4:0] B_NEXT  = 5'h10;
	localparam logic [4:0] B_MINUS = 5'h08;
	localparam logic [4:0] B_PLUS  = 5'h04;
	localparam logic [4:0] B_SYNC  = 5'h02;
	localparam logic [4:0] B_START = 5'h01;

	logic                      i_clk;
	logic                      i_rstn;
	tsd_pkg::buttons_s         buttons;
	logic                      ext_pulse;
	logic                      tune_pos;
	logic                      tune_neg;
	logic [9:0]                fault;
	logic [4:0]                addr;
	logic [31:0]               wdata;
	logic [31:0]               rdata;
	logic                      wr;
	logic                      rd;
	logic [6:0]                segments;
	logic [6:0]                digit_sel;
	logic [6:0]                fault_segments;
	tsd_pkg::indicator_lamp_s  lamps;
	logic                      aux_pulse;
	int                        fail_count;
	int                        total_checks;

	time_scale_display_control #(.PULSE_TICKS(5), .HOLD_TICKS(20), .DEB_TICKS(2),
		.SCAN_TICKS(3), .GATE_TICKS(50)) dut (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_buttons(buttons), .i_ext_pulse(ext_pulse),
		.i_tune_pos(tune_pos), .i_tune_neg(tune_neg), .i_fault(fault), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_segments(segments),
		.o_digit_sel(digit_sel), .o_fault_segments(fault_segments), .o_lamps(lamps),
		.o_aux_pulse(aux_pulse));

	panel_operator_model op (
		.i_clk(i_clk), .o_buttons(buttons), .o_ext_pulse(ext_pulse),
		.o_tune_pos(tune_pos), .o_tune_neg(tune_neg), .o_fault(fault));

	// 40 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end

	// Expected segment pattern {g..a} of a decimal digit
	function automatic logic [6:0] seg7(input int d);
		logic [6:0] t [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66,
			7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
		return t[d];
	endfunction

	task automatic tick();
		@(posedge i_clk);
		#1;
	endtask

	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		@(posedge i_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge i_clk);
		wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
		@(posedge i_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge i_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic check_reg(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] d;
		rd_reg(a, d);
		`CHK(d, e)
	endtask

	task automatic end_test(input string name);
		$display("test %s finished, mismatches so far %0d", name, fail_count);
	endtask

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Watchdog well past the expected run length
	initial begin
		#(20000 * 25);
		fail_count++;
		print_verdict();
	end

	// Main sequence
	initial begin
		int n;
		logic [31:0] v;
		logic [31:0] s;
		logic p;
		i_rstn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 5'h00;
		wdata = 32'h0;
		fail_count = 0;
		total_checks = 0;
		v = $urandom(32'h4a7e);
		repeat (4) @(posedge i_clk);
		i_rstn <= 1'b1;
		// Pulse width from the first scale match
		n = 0;
		while (aux_pulse !== 1'b1 && n < 200) begin tick(); n++; end
		n = 0;
		while (aux_pulse === 1'b1 && n < 100) begin tick(); n++; end
		`CHK(n, 20)
		// Least digit of the time display, scanned one at a time
		n = 0;
		while (digit_sel !== 7'h01 && n < 200) begin tick(); n++; end
		`CHK(segments, seg7(0))
		`CHK($onehot(digit_sel), 1'b1)
		check_reg(tsd_pkg::A_TOD, 32'h0);
		check_reg(tsd_pkg::A_SHIFT, 32'h0);
		check_reg(5'h14, 32'h0);
		end_test("reset");
		// Panel switch settings read back, random values
		for (int i = 0; i < 8; i++) begin
			v = $urandom;
			wr_reg(tsd_pkg::A_CTRL, v);
			check_reg(tsd_pkg::A_CTRL, {26'h0, v[5:0]});
		end
		wr_reg(tsd_pkg::A_CTRL, 32'h20);
		end_test("ctrl");
		// Every fault line, with random tune polarity
		for (int k = 0; k < 10; k++) begin
			p = 1'($urandom);
			op.set_inputs(10'h1 << k, p, ~p);
			rd_reg(tsd_pkg::A_STATUS, s);
			`CHK(s[11:8], 4'(k + 1))
			`CHK(lamps.red, 1'b1)
			`CHK(lamps.green, 1'b0)
			`CHK(fault_segments, seg7((k + 1) % 10))
			`CHK(lamps.tune_plus, p)
			`CHK(lamps.tune_minus, ~p)
		end
		op.set_inputs(10'h0, 1'b0, 1'b0);
		#1;
		`CHK(lamps.green, 1'b1)
		`CHK(lamps.red, 1'b0)
		`CHK(lamps.tune_plus, 1'b0)
		wr_reg(tsd_pkg::A_CTRL, 32'h0);
		end_test("faults");
		// Shift entry, arming, and leaving the interval function
		op.press(B_NEXT, 40);
		rd_reg(tsd_pkg::A_STATUS, s);
		`CHK(s[13:12], 2'd1)
		`CHK(lamps.fn_dt, 1'b1)
		op.press(B_PLUS, 40);
		check_reg(tsd_pkg::A_SHIFT, 32'h1);
		op.press(B_START, 40);
		op.press(B_MINUS, 40);
		check_reg(tsd_pkg::A_SHIFT, 32'h91);
		op.press(B_START | B_SYNC, 160);
		rd_reg(tsd_pkg::A_STATUS, s);
		`CHK(s[14], 1'b1)
		op.press(B_NEXT, 40);
		rd_reg(tsd_pkg::A_STATUS, s);
		`CHK(s[13:12], 2'd2)
		`CHK(s[14], 1'b0)
		`CHK(lamps.fn_df, 1'b1)
		op.press(B_NEXT, 40);
		rd_reg(tsd_pkg::A_STATUS, s);
		`CHK(s[13:12], 2'd3)
		`CHK(digit_sel, 7'h00)
		`CHK(lamps.scale_flash, 1'b1)
		op.press(B_NEXT, 40);
		rd_reg(tsd_pkg::A_STATUS, s);
		`CHK(s[13:12], 2'd0)
		end_test("shift");
		// Time setting with seconds wrap below zero
		wr_reg(tsd_pkg::A_CTRL, 32'h10);
		op.press(B_PLUS, 40);
		check_reg(tsd_pkg::A_TOD, 32'h1);
		op.press(B_MINUS, 40);
		op.press(B_MINUS, 40);
		check_reg(tsd_pkg::A_TOD, 32'h59);
		wr_reg(tsd_pkg::A_CTRL, 32'h0);
		end_test("time");
		// Outside reference: sync on its pulse, one period is 100 ticks
		wr_reg(tsd_pkg::A_CTRL, 32'h01);
		op.press(B_NEXT, 40);
		op.press(B_START | B_SYNC, 160);
		n = 0;
		s = 32'h4000;
		while (s[14] !== 1'b0 && n < 500) begin rd_reg(tsd_pkg::A_STATUS, s); n++; end
		`CHK(s[14], 1'b0)
		`CHK(s[13:12], 2'd1)
		repeat (450) @(posedge i_clk);
		rd_reg(tsd_pkg::A_VALUE, v);
		`CHK((v == 32'h99) || (v == 32'h100), 1'b1)
		end_test("outside");
		print_verdict();
	end
endmodule
